// ---- cog_pkg.sv ----
package cog_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] FREQ_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam logic [7:0] WDOG_OFS = 8'h0C;
    localparam int CTRL_SW_SEL = 0;
    localparam int CTRL_WD_EN = 1;
    localparam int CTRL_RST_WD = 2;
    localparam int CTRL_RST_FREQ = 3;
    localparam int CTRL_KICK = 4;
    localparam int FREQ_W = 16;
    localparam logic [15:0] FREQ_RESET = 16'h0000;
    localparam logic [15:0] WDOG_RESET = 16'hFFFF;
    localparam int STRAP_W = 5;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 10;
    localparam int RST_PULSE_NS = 1000;
    localparam int RST_PULSE_CYC = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int STRAP_SETTLE = 4;
    localparam int NUM_SLOT = 9;
    localparam int NUM_GFX = 3;
    localparam int NUM_REF = 3;
endpackage

// ---- cog_gate.sv ----
`timescale 1ns/1ps
// Glitch-free stop of one clock: the enable is taken only while the source is low.
module cog_gate (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Source and control
    input wire logic src_i,
    input wire logic run_i,
    // Gated output
    output logic clk_o
);
    typedef struct packed {
        logic en;
        logic out;
    } cog_gate_s;
    cog_gate_s st_reg, st_next;

    always_comb begin
        st_next = st_reg;
        if (!src_i) begin
            st_next.en = run_i;
        end
        st_next.out = src_i & (src_i ? st_reg.en : run_i);
        if (!src_i) begin
            st_next.out = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign clk_o = st_reg.out;
endmodule

// ---- cog_top.sv ----
`timescale 1ns/1ps
// What this block does
// - Reference halt low stops reference, dual-rate and fixed 48 MHz outputs.
// - Slot halt low stops nine slot clocks and the early slot clock.
// - Free-running slot clock toggles once the straps are latched, ignoring the slot halt.
// - Graphics halt low stops all three graphics-port clocks.
// - Processor halt low stops both chipset differential clock outputs.
// - Graphics-port rate derives from five frequency straps, nominal 66 MHz.
// - Five frequency straps are read from shared clock output pins.
// - Rate strap on first slot pin picks 24 or 48 MHz dual-rate.
// - Fixed and dual-rate outputs carry no frequency modulation.
// - Watchdog expiry switches frequency to strap or software value.
// - Open-drain reset pulses after watchdog timeout or software frequency change.
// - Output frequency is programmable in steps below 1 MHz.
module cog_top
    import cog_pkg::*;
#(
    parameter int WDOG_W = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Clock sources from the synthesiser
    input wire logic ref_src_i,
    input wire logic usb_src_i,
    input wire logic half_src_i,
    input wire logic slot_src_i,
    input wire logic gfx_src_i,
    input wire logic cpu_src_i,
    input wire logic mod_src_i,
    // Halt inputs, active low
    input wire logic ref_halt_n_i,
    input wire logic slot_halt_n_i,
    input wire logic graphics_port_halt_n_i,
    input wire logic cpu_halt_n_i,
    // Strap levels seen on shared pins
    input wire logic [STRAP_W-1:0] freq_select_straps_i,
    input wire logic dual_rate_strap_n_i,
    // Clock outputs
    output logic [NUM_REF-1:0] reference_clks_o,
    output logic fixed_usb_clk_o,
    output logic dual_rate_clk_o,
    output logic free_slot_clk_o,
    output logic [NUM_SLOT-1:0] slot_clks_o,
    output logic early_slot_clk_o,
    output logic [NUM_GFX-1:0] graphics_port_clks_o,
    output logic chipset_clk_true_o,
    output logic chipset_clk_comp_o,
    // Strap pin direction, high while driving
    output logic strap_pins_oe_o,
    // Frequency selection to the synthesiser
    output logic [FREQ_W-1:0] freq_word_o,
    output logic [STRAP_W-1:0] gfx_rate_sel_o,
    output logic dual_rate_48_o,
    // Open-drain system reset
    output logic sys_rst_o,
    output logic sys_rst_oe_o
);
    import cog_pkg::*;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic [4:0] ctrl;
        logic [FREQ_W-1:0] freq;
        logic [WDOG_W-1:0] wd_load;
        logic [WDOG_W-1:0] wd_cnt;
        logic wd_expired;
        logic [STRAP_W-1:0] straps;
        logic dual48;
        logic [2:0] settle;
        logic latched;
        logic [FREQ_W-1:0] active;
        logic [7:0] rst_cnt;
        logic oe;
    } cog_s;
    cog_s st_reg, st_next;

    function automatic logic wr_hit(input logic [7:0] ofs);
        wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !st_reg.ack && wb_adr_i == ofs;
    endfunction

    // ----------------------------------------
    // Registers, straps, watchdog, reset pulse
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.ack = wb_cyc_i && wb_stb_i && !st_reg.ack;
        st_next.dat = 32'h0000_0000;
        unique case (wb_adr_i)
            CTRL_OFS: st_next.dat[4:0] = st_reg.ctrl;
            FREQ_OFS: st_next.dat[FREQ_W-1:0] = st_reg.freq;
            STAT_OFS: st_next.dat = {24'h00_0000, st_reg.dual48, st_reg.wd_expired, st_reg.latched, st_reg.straps};
            WDOG_OFS: st_next.dat[WDOG_W-1:0] = st_reg.wd_load;
            default: st_next.dat = 32'h0000_0000;
        endcase
        // Straps are read while the shared pins are released, then the pins drive clocks.
        if (!st_reg.latched) begin
            st_next.settle = st_reg.settle + 3'h1;
            if (st_reg.settle == 3'(STRAP_SETTLE)) begin
                st_next.straps = freq_select_straps_i;
                st_next.dual48 = !dual_rate_strap_n_i;
                st_next.latched = 1'b1;
                st_next.oe = 1'b1;
                st_next.active = {{(FREQ_W-STRAP_W){1'b0}}, freq_select_straps_i};
            end
        end
        if (wr_hit(CTRL_OFS) && wb_sel_i[0]) begin
            st_next.ctrl = wb_dat_i[4:0];
            st_next.ctrl[CTRL_KICK] = 1'b0;
        end
        if (wr_hit(WDOG_OFS)) begin
            st_next.wd_load = wb_dat_i[WDOG_W-1:0];
        end
        if (wr_hit(FREQ_OFS)) begin
            st_next.freq = wb_dat_i[FREQ_W-1:0];
            st_next.active = wb_dat_i[FREQ_W-1:0];
            if (st_reg.ctrl[CTRL_RST_FREQ]) begin
                st_next.rst_cnt = 8'(RST_PULSE_CYC);
            end
        end
        if (st_reg.ctrl[CTRL_WD_EN] && !st_reg.wd_expired) begin
            if (wr_hit(CTRL_OFS) && wb_dat_i[CTRL_KICK]) begin
                st_next.wd_cnt = st_reg.wd_load;
            end else if (st_reg.wd_cnt == '0) begin
                st_next.wd_expired = 1'b1;
                st_next.active = st_reg.ctrl[CTRL_SW_SEL] ? st_reg.freq
                    : {{(FREQ_W-STRAP_W){1'b0}}, st_reg.straps};
                if (st_reg.ctrl[CTRL_RST_WD]) begin
                    st_next.rst_cnt = 8'(RST_PULSE_CYC);
                end
            end else begin
                st_next.wd_cnt = st_reg.wd_cnt - 1'b1;
            end
        end else if (!st_reg.ctrl[CTRL_WD_EN]) begin
            st_next.wd_cnt = st_reg.wd_load;
            st_next.wd_expired = 1'b0;
        end
        if (st_reg.rst_cnt != 8'h00 && st_next.rst_cnt == st_reg.rst_cnt) begin
            st_next.rst_cnt = st_reg.rst_cnt - 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
            st_reg.freq <= FREQ_RESET;
            st_reg.wd_load <= WDOG_W'(WDOG_RESET);
            st_reg.wd_cnt <= WDOG_W'(WDOG_RESET);
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // Output gating
    // ----------------------------------------
    logic half_or_full;
    assign half_or_full = st_reg.dual48 ? usb_src_i : half_src_i;

    logic [NUM_REF+NUM_SLOT+NUM_GFX+5:0] src_v, run_v, out_v;
    assign src_v = {{NUM_REF{ref_src_i}}, usb_src_i, half_or_full, {(NUM_SLOT+1){slot_src_i}},
        slot_src_i, {NUM_GFX{gfx_src_i}}, cpu_src_i, !cpu_src_i};
    assign run_v = {{(NUM_REF+2){ref_halt_n_i & st_reg.latched}},
        {(NUM_SLOT+1){slot_halt_n_i & st_reg.latched}},
        st_reg.latched,
        {NUM_GFX{graphics_port_halt_n_i}},
        {2{cpu_halt_n_i}}};

    genvar g;
    generate
        for (g = 0; g < NUM_REF + NUM_SLOT + NUM_GFX + 6; g++) begin : gen_gate
            cog_gate u_gate (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .src_i(src_v[g]),
                .run_i(run_v[g]),
                .clk_o(out_v[g])
            );
        end
    endgenerate

    assign {reference_clks_o, fixed_usb_clk_o, dual_rate_clk_o, slot_clks_o, early_slot_clk_o,
        free_slot_clk_o, graphics_port_clks_o, chipset_clk_true_o, chipset_clk_comp_o} = out_v;

    logic unused_mod;
    assign unused_mod = mod_src_i;

    assign wb_ack_o = st_reg.ack;
    assign wb_dat_o = st_reg.dat;
    assign strap_pins_oe_o = st_reg.oe;
    assign freq_word_o = st_reg.active;
    assign gfx_rate_sel_o = st_reg.straps;
    assign dual_rate_48_o = st_reg.dual48;
    assign sys_rst_o = 1'b0;
    assign sys_rst_oe_o = st_reg.rst_cnt != 8'h00;
endmodule

// ---- cog_monitor.sv ----
`timescale 1ns/1ps
module cog_monitor (
    input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o, slot_src_i, gfx_src_i,
    input wire logic ref_halt_n_i, slot_halt_n_i, graphics_port_halt_n_i, cpu_halt_n_i,
    input wire logic dual_rate_strap_n_i, fixed_usb_clk_o, dual_rate_clk_o, free_slot_clk_o,
    input wire logic early_slot_clk_o, chipset_clk_true_o, chipset_clk_comp_o, strap_pins_oe_o,
    input wire logic dual_rate_48_o, sys_rst_oe_o,
    input wire logic [cog_pkg::STRAP_W-1:0] freq_select_straps_i, gfx_rate_sel_o,
    input wire logic [cog_pkg::NUM_REF-1:0] reference_clks_o,
    input wire logic [cog_pkg::NUM_SLOT-1:0] slot_clks_o,
    input wire logic [cog_pkg::NUM_GFX-1:0] graphics_port_clks_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // The reset pin is held for ten cycles and then let go.
    sequence ten_low;
        sys_rst_oe_o [*8] ##1 sys_rst_oe_o [*2] ##1 !sys_rst_oe_o;
    endsequence
    a_bus_ack_taken: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_bus_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ref_group_stop: assert property (
        !ref_halt_n_i [*4] |=> !(|reference_clks_o || fixed_usb_clk_o || dual_rate_clk_o))
        else $error("reference group runs");
    a_slot_group_stop: assert property (
        !slot_halt_n_i [*4] |=> !(|slot_clks_o || early_slot_clk_o)) else $error("slot group runs");
    a_free_slot_runs: assert property (
        strap_pins_oe_o [*3] |-> free_slot_clk_o == $past(slot_src_i)) else $error("free slot stuck");
    a_gfx_group_stop: assert property (
        !graphics_port_halt_n_i [*4] |=> !(|graphics_port_clks_o)) else $error("graphics runs");
    a_chipset_pair_stop: assert property (
        !cpu_halt_n_i [*4] |=> !(chipset_clk_true_o || chipset_clk_comp_o)) else $error("pair runs");
    a_gfx_clean_edge: assert property (
        $rose(graphics_port_clks_o[0]) |-> $past(gfx_src_i)) else $error("short pulse");
    a_strap_latch_value: assert property (
        $rose(strap_pins_oe_o) |-> gfx_rate_sel_o == freq_select_straps_i
        && dual_rate_48_o == !dual_rate_strap_n_i) else $error("strap latch wrong");
    a_rst_pulse_len: assert property ($rose(sys_rst_oe_o) |-> ten_low)
        else $error("reset pulse length");
endmodule
bind cog_top cog_monitor u_cog_monitor (.*);

// ---- cog_pm_model.sv ----
`timescale 1ns/1ps
module cog_pm_model (
    input wire logic clk_i,
    input wire logic [3:0] halt_req_i,
    input wire logic sys_rst_o,
    input wire logic sys_rst_oe_o,
    output logic src_o = 1'b0,
    output logic [3:0] halt_n_o,
    output wire board_rst_n_o
);
    always @(posedge clk_i) begin
        src_o <= ~src_o;
    end
    assign halt_n_o = ~halt_req_i;
    // The board pull-up lifts the reset line whenever the device lets go.
    assign board_rst_n_o = sys_rst_oe_o ? sys_rst_o : 1'b1;
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import cog_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF, hreq = 4'h0, halt_n;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic src, wb_ack_o, fixed_usb_clk_o, dual_rate_clk_o, free_slot_clk_o, early_slot_clk_o;
    logic chipset_clk_true_o, chipset_clk_comp_o, strap_pins_oe_o, dual_rate_48_o, sys_rst_o, sys_rst_oe_o;
    logic [NUM_REF-1:0] reference_clks_o;
    logic [NUM_SLOT-1:0] slot_clks_o;
    logic [NUM_GFX-1:0] graphics_port_clks_o;
    logic [FREQ_W-1:0] freq_word_o;
    logic [STRAP_W-1:0] gfx_rate_sel_o;
    wire board_rst_n;
    int miscompares = 0, n_compared = 0, low_cycles = 0;
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) if (board_rst_n === 1'b0) low_cycles++;
    cog_top #(.WDOG_W(16)) u_cog_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .ref_src_i(src), .usb_src_i(src), .half_src_i(src), .slot_src_i(src),
        .gfx_src_i(src), .cpu_src_i(src), .mod_src_i(src), .ref_halt_n_i(halt_n[0]), .slot_halt_n_i(halt_n[1]),
        .graphics_port_halt_n_i(halt_n[2]), .cpu_halt_n_i(halt_n[3]), .freq_select_straps_i(5'h15),
        .dual_rate_strap_n_i(1'b0), .reference_clks_o, .fixed_usb_clk_o, .dual_rate_clk_o, .free_slot_clk_o,
        .slot_clks_o, .early_slot_clk_o, .graphics_port_clks_o, .chipset_clk_true_o, .chipset_clk_comp_o,
        .strap_pins_oe_o, .freq_word_o, .gfx_rate_sel_o, .dual_rate_48_o, .sys_rst_o, .sys_rst_oe_o);
    cog_pm_model u_cog_pm_model (.clk_i, .halt_req_i(hreq), .sys_rst_o, .sys_rst_oe_o, .src_o(src),
        .halt_n_o(halt_n), .board_rst_n_o(board_rst_n));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // One bit per clock group, set when any output of that group is high.
    function automatic logic [4:0] live();
        return {free_slot_clk_o, chipset_clk_true_o | chipset_clk_comp_o, |graphics_port_clks_o,
            |slot_clks_o | early_slot_clk_o, |reference_clks_o | fixed_usb_clk_o | dual_rate_clk_o};
    endfunction
    task automatic t_straps();
        chk(32'(strap_pins_oe_o), 32'h1);
        chk(32'(gfx_rate_sel_o), 32'h15);
        chk(32'(dual_rate_48_o), 32'h1);
        bus(1'b0, STAT_OFS, 32'h0);
        chk(q, 32'hB5);
        bus(1'b0, WDOG_OFS, 32'h0);
        chk(q, 32'(WDOG_RESET));
        bus(1'b1, 8'h10, 32'hFF);
        bus(1'b0, 8'h10, 32'h0);
        chk(q, 32'h0);
    endtask
    task automatic t_halts();
        logic [4:0] seen;
        for (int i = 0; i < 4; i++) begin
            hreq <= 4'(1 << i);
            repeat (6) @(posedge clk_i);
            seen = 5'h00;
            repeat (8) begin
                @(posedge clk_i);
                seen |= live();
            end
            chk(32'(seen), 32'(5'h1F ^ 5'(1 << i)));
        end
        hreq <= 4'h0;
    endtask
    task automatic t_freq_reset();
        bus(1'b1, CTRL_OFS, 32'h08);
        low_cycles = 0;
        bus(1'b1, FREQ_OFS, 32'h1235);
        repeat (30) @(posedge clk_i);
        chk(32'(low_cycles), 32'(RST_PULSE_CYC));
        bus(1'b0, FREQ_OFS, 32'h0);
        chk(q, 32'h1235);
    endtask
    task automatic t_watchdog();
        bus(1'b1, WDOG_OFS, 32'h20);
        low_cycles = 0;
        bus(1'b1, CTRL_OFS, 32'h06);
        repeat (200) @(posedge clk_i);
        chk(32'(freq_word_o), 32'h15);
        chk(32'(low_cycles), 32'(RST_PULSE_CYC));
        bus(1'b0, STAT_OFS, 32'h0);
        chk(q, 32'hF5);
    endtask
    task automatic test_done();
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        t_straps();
        t_halts();
        t_freq_reset();
        t_watchdog();
        test_done();
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        miscompares++;
        $display("Error at %0t: timeout", $time);
        test_done();
    end
endmodule
